// ==== strap_board.sv ====
`timescale 1ns/10ps
module strap_board (
  input  wire logic [9:0] level_i,
  output logic      [9:0] strap_o
);
  // Board levels reach the strap pins unchanged; the duplex pin is one
  // of them, and the port 0 manual strap stays driven in MAC mode too
  assign strap_o = level_i;
endmodule // strap_board

// ==== strap_defaults.sv ====
// Functional notes
// R01: Port 2 strap low: autoneg pause, advertise symmetric pause bit 10.
// R02: Port 2 strap high: pause from tx/rx enables, bit 10 cleared.
// R03: Partner ability built from speed strap, duplex polarity and duplex pin.
// R04: Fallback speed is 10Mbps on low speed strap, 100Mbps on high.
// R05: Full duplex when duplex pin equals polarity strap, else half duplex.
// R06: Port 0 backpressure enable defaults from its strap.
// R07: Port 0 tx and rx pause enables default from full-duplex strap.
// R08: Port 0 manual pause select defaults from its strap.
// R09: In MAC mode the port 0 manual strap is ignored; host sets pause.
// R10: Heartbeat-off bit 0 defaults to its strap value.
// R11: The EEPROM loader may override soft-strap values.
// R12: Straps load only as defaults; software rewrites stay.
`timescale 1ns/10ps
module strap_defaults
  import strap_defaults_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  input  wire logic        PORT2_MANUAL_STRAP_I,
  input  wire logic        PORT2_PAUSE_STRAP_I,
  input  wire logic        EXT_SPEED_STRAP_I,
  input  wire logic        EXT_DUPLEX_POL_STRAP_I,
  input  wire logic        EXT_DUPLEX_PIN_I,
  input  wire logic        EXT_BACKPRESS_STRAP_I,
  input  wire logic        EXT_PAUSE_STRAP_I,
  input  wire logic        EXT_MANUAL_STRAP_I,
  input  wire logic        HEARTBEAT_OFF_STRAP_I,
  input  wire logic        MAC_MODE_I,
  input  wire logic [31:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [31:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic             PORT2_MANUAL_O,
  output logic             PORT2_TX_PAUSE_O,
  output logic             PORT2_RX_PAUSE_O,
  output logic             EXT_MANUAL_O,
  output logic             EXT_TX_PAUSE_O,
  output logic             EXT_RX_PAUSE_O,
  output logic             EXT_BACKPRESS_O,
  output logic             EXT_FALLBACK_100_O,
  output logic             EXT_FULL_DUPLEX_O,
  output logic             HEARTBEAT_OFF_O,
  output logic             SYM_PAUSE_ADV_O
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_LATCH = 2'h0,
    ST_RUN   = 2'h1
  } phase_type;

  typedef struct packed {
    phase_type   phase;
    logic [3:0]  port2;
    logic [3:0]  ext;
    logic        heartbeat;
    logic        advert;
    logic        speed;
    logic        duplex;
    logic        mac;
    logic [31:0] aw_addr;
    logic        aw_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_full;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_type;

  state_type cur;
  state_type next_cur;

  logic [31:0] partner;
  logic        do_write;
  logic        do_read;
  logic        full_dup;
  logic [31:0] wmask;

  // Duplex resolved from pin level against polarity strap
  assign full_dup = (EXT_DUPLEX_PIN_I == EXT_DUPLEX_POL_STRAP_I); // [R05]

  // Partner ability word from the stored speed and duplex
  always_comb begin
    partner = 32'h0000_0000;
    partner[4:0] = SELECTOR_8023;
    partner[LP_100FD_BIT] = cur.speed & cur.duplex; // [R03]
    partner[LP_100HD_BIT] = cur.speed & ~cur.duplex; // [R03]
    partner[LP_10FD_BIT]  = ~cur.speed & cur.duplex; // [R03]
    partner[LP_10HD_BIT]  = ~cur.speed & ~cur.duplex; // [R03]
    partner[LP_PAUSE_BIT] = cur.duplex;
  end

  // Byte-lane mask for writes
  always_comb begin
    wmask = {{8{cur.w_strb[3]}}, {8{cur.w_strb[2]}},
             {8{cur.w_strb[1]}}, {8{cur.w_strb[0]}}};
  end

  assign AWREADY  = ~cur.aw_full & (cur.phase == ST_RUN);
  assign WREADY   = ~cur.w_full & (cur.phase == ST_RUN);
  assign ARREADY  = ~cur.rvalid & (cur.phase == ST_RUN);
  assign do_write = cur.aw_full & cur.w_full & ~cur.bvalid;
  assign do_read  = ARVALID & ARREADY;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    wv = cur.w_data & wmask;
    next_cur = cur;
    unique case (cur.phase)
      ST_LATCH: begin
        // Straps captured once after reset release
        next_cur.port2[MANUAL_BIT]   = PORT2_MANUAL_STRAP_I;
        next_cur.port2[TX_PAUSE_BIT] = PORT2_PAUSE_STRAP_I;
        next_cur.port2[RX_PAUSE_BIT] = PORT2_PAUSE_STRAP_I;
        next_cur.advert = ~PORT2_MANUAL_STRAP_I; // [R01] [R02]
        next_cur.ext[BACKPRESS_BIT] = EXT_BACKPRESS_STRAP_I; // [R06]
        next_cur.ext[TX_PAUSE_BIT]  = EXT_PAUSE_STRAP_I; // [R07]
        next_cur.ext[RX_PAUSE_BIT]  = EXT_PAUSE_STRAP_I; // [R07]
        // MAC mode ignores the strap and forces manual control on
        next_cur.ext[MANUAL_BIT] = MAC_MODE_I ? 1'b1
                                              : EXT_MANUAL_STRAP_I; // [R08] [R09]
        next_cur.heartbeat = HEARTBEAT_OFF_STRAP_I; // [R10]
        next_cur.speed  = EXT_SPEED_STRAP_I; // [R04]
        next_cur.duplex = full_dup; // [R05]
        next_cur.mac    = MAC_MODE_I;
        next_cur.phase  = ST_RUN; // [R12]
      end
      ST_RUN: begin
        if (AWVALID && AWREADY) begin
          next_cur.aw_addr = AWADDR;
          next_cur.aw_full = 1'b1;
        end
        if (WVALID && WREADY) begin
          next_cur.w_data = WDATA;
          next_cur.w_strb = WSTRB;
          next_cur.w_full = 1'b1;
        end
        if (do_write) begin
          next_cur.aw_full = 1'b0;
          next_cur.w_full  = 1'b0;
          next_cur.bvalid  = 1'b1;
          next_cur.bresp   = RESP_OKAY;
          // Software and loader writes replace defaults for good
          unique case (cur.aw_addr[7:0])
            PORT2_CTRL_ADDR: begin
              next_cur.port2 = (cur.port2 & ~wmask[3:0]) | wv[3:0]; // [R12]
              next_cur.advert = ~((cur.port2[MANUAL_BIT] & ~wmask[0])
                                  | wv[MANUAL_BIT]); // [R01] [R02]
            end
            EXT_CTRL_ADDR:
              next_cur.ext = (cur.ext & ~wmask[3:0]) | wv[3:0]; // [R12]
            VPHY_CTRL_ADDR:
              if (wmask[HEARTBEAT_BIT])
                next_cur.heartbeat = wv[HEARTBEAT_BIT];
            LOADER_ADDR: begin
              // Loader override of the port 0 fallback straps
              if (wmask[ST_SPEED_BIT])
                next_cur.speed = wv[ST_SPEED_BIT]; // [R11]
              if (wmask[ST_DUPLEX_BIT])
                next_cur.duplex = wv[ST_DUPLEX_BIT]; // [R11]
            end
            default: next_cur.bresp = RESP_SLVERR;
          endcase
        end
        if (cur.bvalid && BREADY)
          next_cur.bvalid = 1'b0;
        if (cur.rvalid && RREADY)
          next_cur.rvalid = 1'b0;
        if (do_read) begin
          next_cur.rvalid = 1'b1;
          next_cur.rresp  = RESP_OKAY;
          next_cur.rdata  = 32'h0000_0000;
          unique case (ARADDR[7:0])
            PORT2_CTRL_ADDR: next_cur.rdata[3:0] = cur.port2;
            EXT_CTRL_ADDR:   next_cur.rdata[3:0] = cur.ext;
            VPHY_CTRL_ADDR:
              next_cur.rdata[HEARTBEAT_BIT] = cur.heartbeat;
            PARTNER_ADDR:    next_cur.rdata = partner; // [R03]
            ADVERT_ADDR:
              next_cur.rdata[SYM_PAUSE_BIT] = cur.advert; // [R01]
            LOADER_ADDR, STATUS_ADDR: begin
              next_cur.rdata[ST_SPEED_BIT]  = cur.speed;
              next_cur.rdata[ST_DUPLEX_BIT] = cur.duplex;
              next_cur.rdata[ST_MAC_BIT]    = cur.mac;
              next_cur.rdata[ST_DONE_BIT]   = 1'b1;
            end
            default: next_cur.rresp = RESP_SLVERR;
          endcase
        end
      end
      default: next_cur.phase = ST_LATCH;
    endcase
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from state flops
  assign BVALID             = cur.bvalid;
  assign BRESP              = cur.bresp;
  assign RVALID             = cur.rvalid;
  assign RDATA              = cur.rdata;
  assign RRESP              = cur.rresp;
  assign PORT2_MANUAL_O     = cur.port2[MANUAL_BIT];
  assign PORT2_TX_PAUSE_O   = cur.port2[TX_PAUSE_BIT];
  assign PORT2_RX_PAUSE_O   = cur.port2[RX_PAUSE_BIT];
  assign EXT_MANUAL_O       = cur.ext[MANUAL_BIT];
  assign EXT_TX_PAUSE_O     = cur.ext[TX_PAUSE_BIT];
  assign EXT_RX_PAUSE_O     = cur.ext[RX_PAUSE_BIT];
  assign EXT_BACKPRESS_O    = cur.ext[BACKPRESS_BIT];
  assign EXT_FALLBACK_100_O = cur.speed; // [R04]
  assign EXT_FULL_DUPLEX_O  = cur.duplex; // [R05]
  assign HEARTBEAT_OFF_O    = cur.heartbeat;
  assign SYM_PAUSE_ADV_O    = cur.advert;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  sequence latch_s;
    cur.phase == ST_LATCH;
  endsequence

  adv_low_strap_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    latch_s |=> (SYM_PAUSE_ADV_O == ~$past(PORT2_MANUAL_STRAP_I))) // [R01]
    else $error("advertise bit does not follow port 2 strap");
  port2_manual_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    latch_s |=> (PORT2_MANUAL_O != SYM_PAUSE_ADV_O)) // [R02]
    else $error("manual select and advertise disagree");
  speed_default_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    latch_s |=> (EXT_FALLBACK_100_O == $past(EXT_SPEED_STRAP_I))) // [R04]
    else $error("fallback speed not from strap");
  duplex_default_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    latch_s |=> (EXT_FULL_DUPLEX_O ==
      ($past(EXT_DUPLEX_PIN_I) == $past(EXT_DUPLEX_POL_STRAP_I)))) // [R05]
    else $error("duplex not from pin and polarity");
  partner_bits_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    latch_s |=> (partner[LP_100FD_BIT] == ($past(EXT_SPEED_STRAP_I)
      && ($past(EXT_DUPLEX_PIN_I) == $past(EXT_DUPLEX_POL_STRAP_I))))) // [R03]
    else $error("partner ability mismatch");
  backpress_def_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    latch_s |=> (EXT_BACKPRESS_O == $past(EXT_BACKPRESS_STRAP_I))) // [R06]
    else $error("backpressure default wrong");
  ext_pause_def_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    latch_s |=> (EXT_TX_PAUSE_O == $past(EXT_PAUSE_STRAP_I))
                && (EXT_RX_PAUSE_O == $past(EXT_PAUSE_STRAP_I))) // [R07]
    else $error("port 0 pause defaults wrong");
  ext_manual_def_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (latch_s and !MAC_MODE_I) |=>
      (EXT_MANUAL_O == $past(EXT_MANUAL_STRAP_I))) // [R08]
    else $error("port 0 manual default wrong");
  mac_ignore_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (latch_s and MAC_MODE_I) |=> EXT_MANUAL_O) // [R09]
    else $error("MAC mode did not force manual control");
  heartbeat_def_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    latch_s |=> (HEARTBEAT_OFF_O == $past(HEARTBEAT_OFF_STRAP_I))) // [R10]
    else $error("heartbeat default wrong");
  no_relatch_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (cur.phase == ST_RUN) |=> (cur.phase == ST_RUN)) // [R12]
    else $error("straps latched again after reset");
  loader_speed_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    do_write && cur.aw_addr[7:0] == LOADER_ADDR && cur.w_strb[0]
      |=> (EXT_FALLBACK_100_O == $past(cur.w_data[ST_SPEED_BIT]))) // [R11]
    else $error("loader override of speed failed");

endmodule // strap_defaults

// ==== strap_defaults_pkg.sv ====
package strap_defaults_pkg;
  // ---------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] PORT2_CTRL_ADDR  = 8'h00;
  localparam logic [7:0] EXT_CTRL_ADDR    = 8'h04;
  localparam logic [7:0] VPHY_CTRL_ADDR   = 8'h08;
  localparam logic [7:0] PARTNER_ADDR     = 8'h0C;
  localparam logic [7:0] ADVERT_ADDR      = 8'h10;
  localparam logic [7:0] LOADER_ADDR      = 8'h14;
  localparam logic [7:0] STATUS_ADDR      = 8'h18;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int MANUAL_BIT      = 0;
  localparam int TX_PAUSE_BIT    = 1;
  localparam int RX_PAUSE_BIT    = 2;
  localparam int BACKPRESS_BIT   = 3;
  localparam int HEARTBEAT_BIT   = 0;
  localparam int SYM_PAUSE_BIT   = 10;
  localparam int LP_100FD_BIT    = 8;
  localparam int LP_100HD_BIT    = 7;
  localparam int LP_10FD_BIT     = 6;
  localparam int LP_10HD_BIT     = 5;
  localparam int LP_PAUSE_BIT    = 10;
  localparam int ST_SPEED_BIT    = 0;
  localparam int ST_DUPLEX_BIT   = 1;
  localparam int ST_MAC_BIT      = 2;
  localparam int ST_DONE_BIT     = 3;

  // Selector field in partner ability (IEEE 802.3)
  localparam logic [4:0] SELECTOR_8023 = 5'h01;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== test_strap_defaults.sv ====
`timescale 1ns/10ps
module test_strap_defaults;
  import strap_defaults_pkg::*;
  // -------------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------------
  logic        clk;
  logic        rst;
  logic [9:0]  cfg;
  logic [9:0]  s;
  logic [9:0]  c;
  logic [31:0] awaddr, wdata, araddr, rdata, rd, m;
  logic        awvalid, wvalid, bready, arvalid, rready, fd;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic [10:0] o;
  int          miscompares;
  int          check_count;
  int          idx;
  logic [9:0]  cfgs [6] = '{10'h000, 10'h3FF, 10'h155, 10'h0F0, 10'h01C,
                            10'h2AA};

  strap_board i_strap_board (.level_i(cfg), .strap_o(s));
  strap_defaults i_strap_defaults (
    .MCLK_I(clk), .RST_I(rst), .PORT2_MANUAL_STRAP_I(s[0]),
    .PORT2_PAUSE_STRAP_I(s[1]), .EXT_SPEED_STRAP_I(s[2]),
    .EXT_DUPLEX_POL_STRAP_I(s[3]), .EXT_DUPLEX_PIN_I(s[4]),
    .EXT_BACKPRESS_STRAP_I(s[5]), .EXT_PAUSE_STRAP_I(s[6]),
    .EXT_MANUAL_STRAP_I(s[7]), .HEARTBEAT_OFF_STRAP_I(s[8]),
    .MAC_MODE_I(s[9]), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .PORT2_MANUAL_O(o[0]), .PORT2_TX_PAUSE_O(o[1]),
    .PORT2_RX_PAUSE_O(o[2]), .EXT_MANUAL_O(o[3]), .EXT_TX_PAUSE_O(o[4]),
    .EXT_RX_PAUSE_O(o[5]), .EXT_BACKPRESS_O(o[6]),
    .EXT_FALLBACK_100_O(o[7]), .EXT_FULL_DUPLEX_O(o[8]),
    .HEARTBEAT_OFF_O(o[9]), .SYM_PAUSE_ADV_O(o[10]));

  // Free running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Reset with new board levels, then let the latch edge pass
  task automatic restart(input logic [9:0] lv);
    @(posedge clk);
    rst <= 1'b1;
    cfg <= lv;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Ready is sampled in the low phase, where it equals its edge value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk);
    awaddr  <= {24'h0, a};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = awready && !da;
      tw = wready && !dw;
      @(posedge clk);
      if (ta === 1'b1) awvalid <= 1'b0;
      if (tw === 1'b1) wvalid <= 1'b0;
      da = da | (ta === 1'b1);
      dw = dw | (tw === 1'b1);
    end while (!(da && dw));
    do @(negedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    logic t;
    @(posedge clk);
    araddr  <= {24'h0, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end while (t !== 1'b1);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // -------------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    cfg = 10'h000;
    {awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    miscompares = 0;
    check_count = 0;
    foreach (cfgs[k]) begin
      c = cfgs[k];
      restart(c);
      @(negedge clk);
      fd = (c[3] == c[4]);
      check(o[0], c[0]);
      check(o[10], !c[0]);
      check(o[2:1], {2{c[1]}});
      check(o[3], c[7] | c[9]);
      check(o[5:4], {2{c[6]}});
      check(o[6], c[5]);
      check(o[7], c[2]);
      check(o[8], fd);
      check(o[9], c[8]);
      rdr(ADVERT_ADDR);
      check(rd[SYM_PAUSE_BIT], !c[0]);
      rdr(STATUS_ADDR);
      check(rd[3:0], {1'b1, c[9], fd, c[2]});
      if (!c[9]) begin
        idx = c[2] ? (fd ? 8 : 7) : (fd ? 6 : 5);
        m = (32'h1 << idx) | (32'(fd) << LP_PAUSE_BIT)
            | 32'(SELECTOR_8023);
        rdr(PARTNER_ADDR);
        check(rd, m);
      end
      $display("test straps %h done", c);
    end
    // Host writes stay although the board levels change just before them
    cfg <= 10'h3FF;
    wr(PORT2_CTRL_ADDR, 32'h1);
    @(negedge clk);
    check({o[10], o[2:0]}, 4'b0001);
    wr(EXT_CTRL_ADDR, 32'hA);
    @(negedge clk);
    check(o[6:3], 4'b1010);
    wr(VPHY_CTRL_ADDR, 32'h1);
    @(negedge clk);
    check(o[9], 1'b1);
    wr(LOADER_ADDR, 32'h1);
    @(negedge clk);
    check(o[8:7], 2'b01);
    check(rs, RESP_OKAY);
    repeat (5) @(posedge clk);
    @(negedge clk);
    check(o[9:3], 7'b1011010);
    rdr(STATUS_ADDR);
    check(rd[1:0], 2'b01);
    $display("test overrides done");
    wr(8'h40, 32'hFFFFFFFF);
    check(rs, RESP_SLVERR);
    rdr(8'h40);
    check(rs, RESP_SLVERR);
    check(rd, 32'h0);
    check(o[9:3], 7'b1011010);
    $display("test unmapped done");
    finish_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #500000;
    miscompares++;
    finish_test();
  end
endmodule // test_strap_defaults
